//--- inc/sft_pkg.sv
// serial frame transport: shared constants, field layout and checksum helper
// assumes a single 20 MHz module clock and an 8N1 asynchronous host link
//
// Overview of operation
// - tx line stays driven when select deasserts
// - pending execution errors raise service request
// - non-pending execution errors stay quiet by default
// - trigger register 0x28 selects request conditions
// - capability register reloads defaults on reset
// - bits 3:0 report max rate, read-only
// - every rate code up to maximum supported
// - rate codes 0..4 map 9600..115200 baud
// - bits 7:4 current rate, writable, reset zero
// - select rise, bit12 clear: rate zero, flush
// - select rise, bit12 set: flush, keep rate
// - inbound: checksum, resend flag, 27-bit command
// - outbound: checksum, error flag, one, response
// - inbound checksum with top nibble zeroed
// - outbound checksum after bits 27:26 set
// - resend flag set: repeat last valid response
// - error flag mirrors inbound checksum failure
// - xor four bytes, then fold nibbles
// - bytes sent most significant first
// - eight data bits, no parity, one stop
// - select rise resets link and framing
// - start at 9600, never above 115200
package sft_pkg;

    // =========================================================
    // clock and baud
    localparam int CLK_HZ      = 20_000_000;
    localparam int BAUD_0      = 9600;
    localparam int BAUD_1      = 19200;
    localparam int BAUD_2      = 38400;
    localparam int BAUD_3      = 57600;
    localparam int BAUD_4      = 115200;
    localparam int DIV_W       = 12;
    localparam int NBITS       = 8;

    typedef logic [3:0] sft_code_type;

    localparam sft_code_type BAUD_CODE_DEF = 4'h0;
    localparam sft_code_type BAUD_CODE_MAX = 4'h4;

    // bit period in clocks for a rate code, rounded down
    function automatic logic [DIV_W-1:0] baud_div(input sft_code_type code);
        int b;
        case (code)
            4'h1:    b = BAUD_1;
            4'h2:    b = BAUD_2;
            4'h3:    b = BAUD_3;
            4'h4:    b = BAUD_4;
            default: b = BAUD_0;
        endcase
        return DIV_W'(CLK_HZ / b);
    endfunction : baud_div

    // =========================================================
    // capability register layout
    localparam int SUP_LSB     = 0;
    localparam int CUR_LSB     = 4;
    localparam int RMS_BIT     = 12;
    localparam logic [15:0] IO_CAPABILITY_RESET = 16'h0004;
    localparam logic [15:0] IO_CAPABILITY_WMASK = 16'h10f0;

    // =========================================================
    // service request trigger register
    localparam logic [7:0]  SRQ_TRIG_REGNUM = 8'h28;
    localparam int TRIG_XE_PEND   = 0;
    localparam int TRIG_XE_NOPEND = 1;
    localparam int TRIG_CE        = 2;
    localparam logic [15:0] TRIG_RESET = 16'h0001;
    localparam logic [15:0] TRIG_WMASK = 16'h0007;

    // =========================================================
    // frame layout
    localparam int CK_MSB      = 31;
    localparam int CK_LSB      = 28;
    localparam int FLAG_BIT    = 27;
    localparam int FIXED_BIT   = 26;
    localparam int CMD_W       = 27;
    localparam int RSP_W       = 26;
    localparam int FRAME_BYTES = 4;

    // interleaved parity over four bytes, folded to a nibble
    function automatic logic [3:0] bip4(input logic [31:0] w);
        logic [7:0] b8;
        b8 = w[31:24] ^ w[23:16] ^ w[15:8] ^ w[7:0];
        return b8[7:4] ^ b8[3:0];
    endfunction : bip4

    // outbound frame with flags placed before the checksum
    function automatic logic [31:0] mk_out(input logic ce, input logic [RSP_W-1:0] p);
        logic [31:0] w;
        w = {4'h0, ce, 1'b1, p};
        w[CK_MSB:CK_LSB] = bip4(w);
        return w;
    endfunction : mk_out

endpackage : sft_pkg

//--- verilog/sft_uart_rx.sv
// serial frame transport: 8n1 receiver, one byte pulse per character
// assumes rxd_i already synchronised and a stable bit period from the top
`timescale 1ns/1ps
`default_nettype none
module sft_uart_rx (
    // clock and reset
    input  wire logic                     clk_i,
    input  wire logic                     rst_n_i,
    input  wire logic                     flush_i,
    // line and rate
    input  wire logic                     rxd_i,
    input  wire logic [sft_pkg::DIV_W-1:0] div_i,
    // received byte
    output logic      [7:0]               byte_o,
    output logic                          valid_o
);
    import sft_pkg::*;

    typedef enum logic [3:0] {
        R_IDLE  = 4'b0001,
        R_START = 4'b0010,
        R_DATA  = 4'b0100,
        R_STOP  = 4'b1000
    } sft_rx_type;

    sft_rx_type       st_reg, st_next;
    logic [DIV_W-1:0] cnt_reg, cnt_next;
    logic [2:0]       bit_reg, bit_next;
    logic [7:0]       sh_reg, sh_next;
    logic             vld_next;

    // =========================================================
    // next state
    always_comb begin
        st_next  = st_reg;
        cnt_next = cnt_reg - 1'b1;
        bit_next = bit_reg;
        sh_next  = sh_reg;
        vld_next = 1'b0;
        case (st_reg)
            R_IDLE: begin
                cnt_next = div_i >> 1;
                if (!rxd_i) st_next = R_START;
            end
            R_START: begin
                if (cnt_reg == '0) begin
                    // count down to zero inclusive, so a bit lasts exactly div_i clocks
                    cnt_next = div_i - 1'b1;
                    bit_next = '0;
                    st_next  = rxd_i ? R_IDLE : R_DATA; // glitch rejected
                end
            end
            R_DATA: begin
                if (cnt_reg == '0) begin
                    cnt_next = div_i - 1'b1;
                    sh_next  = {rxd_i, sh_reg[7:1]};
                    bit_next = bit_reg + 1'b1;
                    if (bit_reg == 3'(NBITS - 1)) st_next = R_STOP;
                end
            end
            R_STOP: begin
                if (cnt_reg == '0) begin
                    vld_next = rxd_i; // framing error drops the byte
                    st_next  = R_IDLE;
                end
            end
            default: st_next = R_IDLE;
        endcase
        if (flush_i) begin
            st_next  = R_IDLE;
            vld_next = 1'b0;
        end
    end

    // =========================================================
    // registers
    always_ff @(posedge clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            st_reg  <= R_IDLE;
            cnt_reg <= '0;
            bit_reg <= '0;
            sh_reg  <= '0;
            valid_o <= 1'b0;
        end else begin
            st_reg  <= st_next;
            cnt_reg <= cnt_next;
            bit_reg <= bit_next;
            sh_reg  <= sh_next;
            valid_o <= vld_next;
        end
    end

    assign byte_o = sh_reg;

endmodule : sft_uart_rx
`default_nettype wire

//--- verilog/sft_uart_tx.sv
// serial frame transport: 8n1 transmitter
// assumes start_i only while busy_o is low
`timescale 1ns/1ps
`default_nettype none
module sft_uart_tx (
    // clock and reset
    input  wire logic                     clk_i,
    input  wire logic                     rst_n_i,
    input  wire logic                     flush_i,
    // byte and rate
    input  wire logic                     start_i,
    input  wire logic [7:0]               byte_i,
    input  wire logic [sft_pkg::DIV_W-1:0] div_i,
    // line
    output logic                          txd_o,
    output logic                          busy_o
);
    import sft_pkg::*;

    logic [DIV_W-1:0] cnt_reg, cnt_next;
    logic [3:0]       bit_reg, bit_next;
    logic [9:0]       sh_reg, sh_next;
    logic             busy_next;

    // =========================================================
    // next state: start, 8 data lsb first, stop
    always_comb begin
        cnt_next  = cnt_reg;
        bit_next  = bit_reg;
        sh_next   = sh_reg;
        busy_next = busy_o;
        if (!busy_o) begin
            if (start_i) begin
                sh_next   = {1'b1, byte_i, 1'b0};
                // zero is counted too, so a bit stands exactly div_i clocks
                cnt_next  = div_i - 1'b1;
                bit_next  = '0;
                busy_next = 1'b1;
            end
        end else if (cnt_reg == '0) begin
            cnt_next = div_i - 1'b1;
            sh_next  = {1'b1, sh_reg[9:1]};
            bit_next = bit_reg + 1'b1;
            if (bit_reg == 4'(NBITS + 1)) busy_next = 1'b0;
        end else begin
            cnt_next = cnt_reg - 1'b1;
        end
        if (flush_i) begin
            sh_next   = '1;
            busy_next = 1'b0;
        end
    end

    // =========================================================
    // registers; the line idles high and is never released
    always_ff @(posedge clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            cnt_reg <= '0;
            bit_reg <= '0;
            sh_reg  <= '1;
            busy_o  <= 1'b0;
        end else begin
            cnt_reg <= cnt_next;
            bit_reg <= bit_next;
            sh_reg  <= sh_next;
            busy_o  <= busy_next;
        end
    end

    assign txd_o = sh_reg[0];

endmodule : sft_uart_tx
`default_nettype wire

//--- verilog/sft_top.sv
// serial frame transport: framing, checksum, resend, capability register,
// service request line
// assumes the application layer decodes register commands and drives the
// capability and trigger write strobes; one response per delivered command
`timescale 1ns/1ps
`default_nettype none
module sft_top (
    // clock and reset
    input  wire logic              clk_i,
    input  wire logic              rstn_i,
    // serial pins
    input  wire logic              rxd_i,
    input  wire logic              module_select_n_i,
    output logic                   txd_o,
    output logic                   service_request_n_o,
    // command to application
    output logic                   cmd_valid_o,
    output logic [sft_pkg::CMD_W-1:0] cmd_packet_o,
    // response from application
    input  wire logic              rsp_valid_i,
    input  wire logic [sft_pkg::RSP_W-1:0] rsp_packet_i,
    // execution error events
    input  wire logic              xe_event_i,
    input  wire logic              xe_pending_i,
    input  wire logic              srq_ack_i,
    // register access
    input  wire logic              io_capability_we_i,
    input  wire logic [15:0]       io_capability_wdata_i,
    output logic      [15:0]       io_capability_rdata_o,
    input  wire logic              srq_trig_we_i,
    input  wire logic [15:0]       srq_trig_wdata_i,
    output logic      [15:0]       srq_trig_rdata_o
);
    import sft_pkg::*;

    typedef enum logic [2:0] {
        S_RX   = 3'b001,
        S_WAIT = 3'b010,
        S_TX   = 3'b100
    } sft_state_type;

    // =========================================================
    // reset release and pin synchronisers
    logic rst_meta, rst_n;
    logic rxd_m, rxd_s, ms_m, ms_s, ms_prev;

    always_ff @(posedge clk_i or negedge rstn_i) begin
        if (!rstn_i) begin
            rst_meta <= 1'b0;
            rst_n    <= 1'b0;
        end else begin
            rst_meta <= 1'b1;
            rst_n    <= rst_meta;
        end
    end

    always_ff @(posedge clk_i or negedge rst_n) begin
        if (!rst_n) begin
            rxd_m   <= 1'b1;
            rxd_s   <= 1'b1;
            ms_m    <= 1'b0;
            ms_s    <= 1'b0;
            ms_prev <= 1'b0;
        end else begin
            rxd_m   <= rxd_i;
            rxd_s   <= rxd_m;
            ms_m    <= module_select_n_i;
            ms_s    <= ms_m;
            ms_prev <= ms_s;
        end
    end

    logic ms_rise;
    assign ms_rise = ms_s & ~ms_prev;

    // =========================================================
    // capability and trigger registers
    logic [15:0] io_capability_reg, io_capability_next;
    logic [15:0] trig_reg, trig_next;
    logic [3:0]  wr_code;

    assign wr_code = io_capability_wdata_i[CUR_LSB +: 4];

    always_comb begin
        io_capability_next = io_capability_reg;
        trig_next  = trig_reg;
        if (io_capability_we_i) begin
            io_capability_next[RMS_BIT] = io_capability_wdata_i[RMS_BIT];
            // undefined or unsupported codes leave the rate alone
            if (wr_code <= BAUD_CODE_MAX) io_capability_next[CUR_LSB +: 4] = wr_code;
        end
        if (ms_rise) begin
            if (!io_capability_reg[RMS_BIT]) io_capability_next[CUR_LSB +: 4] = BAUD_CODE_DEF;
        end
        io_capability_next = (io_capability_next & IO_CAPABILITY_WMASK) | (IO_CAPABILITY_RESET & ~IO_CAPABILITY_WMASK);
        if (srq_trig_we_i) trig_next = srq_trig_wdata_i & TRIG_WMASK;
    end

    always_ff @(posedge clk_i or negedge rst_n) begin
        if (!rst_n) begin
            io_capability_reg <= IO_CAPABILITY_RESET;
            trig_reg  <= TRIG_RESET;
        end else begin
            io_capability_reg <= io_capability_next;
            trig_reg  <= trig_next;
        end
    end

    assign io_capability_rdata_o    = io_capability_reg;
    assign srq_trig_rdata_o = trig_reg;

    logic [DIV_W-1:0] div;
    assign div = baud_div(io_capability_reg[CUR_LSB +: 4]);

    // =========================================================
    // byte engines; select rise flushes both
    logic [7:0] rx_byte;
    logic       rx_valid, tx_busy;
    logic       tx_start_reg, tx_start_next;
    logic [31:0] tx_sh_reg, tx_sh_next;

    sft_uart_rx u_rx (
        .clk_i   (clk_i),
        .rst_n_i (rst_n),
        .flush_i (ms_rise),
        .rxd_i   (rxd_s),
        .div_i   (div),
        .byte_o  (rx_byte),
        .valid_o (rx_valid)
    );

    sft_uart_tx u_tx (
        .clk_i   (clk_i),
        .rst_n_i (rst_n),
        .flush_i (ms_rise),
        .start_i (tx_start_reg),
        .byte_i  (tx_sh_reg[31:24]),
        .div_i   (div),
        .txd_o   (txd_o),
        .busy_o  (tx_busy)
    );

    // =========================================================
    // frame assembly, check and response
    sft_state_type st_reg, st_next;
    logic [1:0]  bcnt_reg, bcnt_next;
    logic [2:0]  idx_reg, idx_next;
    logic [23:0] rxsh_reg, rxsh_next;
    logic [31:0] frame_reg, frame_next;
    logic [31:0] last_reg, last_next;
    logic        cmdv_next;
    logic [CMD_W-1:0] cmdp_next;
    logic [31:0] in_word;
    logic        frame_done, ck_ok, ce_evt;

    assign in_word    = {rxsh_reg, rx_byte};
    assign frame_done = (st_reg == S_RX) && rx_valid && (bcnt_reg == 2'(FRAME_BYTES - 1));
    assign ck_ok      = in_word[CK_MSB:CK_LSB] == bip4({4'h0, in_word[27:0]});
    assign ce_evt     = frame_done && !ck_ok;

    always_comb begin
        st_next       = st_reg;
        bcnt_next     = bcnt_reg;
        idx_next      = idx_reg;
        rxsh_next     = rxsh_reg;
        frame_next    = frame_reg;
        last_next     = last_reg;
        tx_sh_next    = tx_sh_reg;
        tx_start_next = 1'b0;
        cmdv_next     = 1'b0;
        cmdp_next     = cmd_packet_o;
        case (st_reg)
            S_RX: begin
                if (rx_valid) begin
                    rxsh_next = in_word[23:0];
                    bcnt_next = bcnt_reg + 1'b1;
                end
                if (frame_done) begin
                    idx_next = '0;
                    if (!ck_ok) begin
                        frame_next = mk_out(1'b1, last_reg[RSP_W-1:0]);
                        st_next    = S_TX;
                    end else if (in_word[FLAG_BIT]) begin
                        frame_next = last_reg;
                        st_next    = S_TX;
                    end else begin
                        cmdv_next = 1'b1;
                        cmdp_next = in_word[CMD_W-1:0];
                        st_next   = S_WAIT;
                    end
                    tx_sh_next = frame_next;
                end
            end
            S_WAIT: begin
                if (rsp_valid_i) begin
                    frame_next = mk_out(1'b0, rsp_packet_i);
                    last_next  = frame_next;
                    tx_sh_next = frame_next;
                    st_next    = S_TX;
                end
            end
            S_TX: begin
                // the start pulse masks busy for the cycle it takes to rise
                if (!tx_busy && !tx_start_reg) begin
                    if (idx_reg == 3'(FRAME_BYTES)) begin
                        st_next = S_RX;
                    end else begin
                        tx_start_next = 1'b1;
                        idx_next      = idx_reg + 1'b1;
                    end
                end
                if (tx_start_reg) tx_sh_next = {tx_sh_reg[23:0], 8'h00};
            end
            default: st_next = S_RX;
        endcase
        if (ms_rise) begin
            // drop any partial frame so the next byte is a frame start
            st_next       = S_RX;
            bcnt_next     = '0;
            tx_start_next = 1'b0;
        end
    end

    always_ff @(posedge clk_i or negedge rst_n) begin
        if (!rst_n) begin
            st_reg       <= S_RX;
            bcnt_reg     <= '0;
            idx_reg      <= '0;
            rxsh_reg     <= '0;
            frame_reg    <= '0;
            last_reg     <= '0;
            tx_sh_reg    <= '0;
            tx_start_reg <= 1'b0;
            cmd_valid_o  <= 1'b0;
            cmd_packet_o <= '0;
        end else begin
            st_reg       <= st_next;
            bcnt_reg     <= bcnt_next;
            idx_reg      <= idx_next;
            rxsh_reg     <= rxsh_next;
            frame_reg    <= frame_next;
            last_reg     <= last_next;
            tx_sh_reg    <= tx_sh_next;
            tx_start_reg <= tx_start_next;
            cmd_valid_o  <= cmdv_next;
            cmd_packet_o <= cmdp_next;
        end
    end

    // =========================================================
    // service request, sticky until acknowledged; a new cause wins
    logic srq_set, srq_next;

    assign srq_set = (xe_event_i && xe_pending_i && trig_reg[TRIG_XE_PEND])
                   || (xe_event_i && !xe_pending_i && trig_reg[TRIG_XE_NOPEND])
                   || (ce_evt && trig_reg[TRIG_CE]);

    always_comb begin
        srq_next = service_request_n_o;
        if (srq_ack_i) srq_next = 1'b1;
        if (srq_set)   srq_next = 1'b0;
    end

    always_ff @(posedge clk_i or negedge rst_n) begin
        if (!rst_n) service_request_n_o <= 1'b1;
        else        service_request_n_o <= srq_next;
    end

    // =========================================================
    // checks
    property p_ms_rate;
        @(posedge clk_i) disable iff (!rst_n)
        ms_rise && !io_capability_reg[RMS_BIT] |=> io_capability_reg[CUR_LSB +: 4] == BAUD_CODE_DEF;
    endproperty
    a_ms_rate: assert property (p_ms_rate) else $error("rate not reset on select rise");

    property p_ms_keep;
        @(posedge clk_i) disable iff (!rst_n)
        ms_rise && io_capability_reg[RMS_BIT] && !io_capability_we_i |=> $stable(io_capability_reg[CUR_LSB +: 4]);
    endproperty
    a_ms_keep: assert property (p_ms_keep) else $error("rate changed on select rise");

    property p_sup_ro;
        @(posedge clk_i) disable iff (!rst_n)
        io_capability_we_i |=> io_capability_reg[SUP_LSB +: 4] == BAUD_CODE_MAX && io_capability_reg[15:13] == 3'h0;
    endproperty
    a_sup_ro: assert property (p_sup_ro) else $error("read-only capability bits changed");

    property p_rsv;
        @(posedge clk_i) disable iff (!rst_n)
        io_capability_we_i ##1 1'b1 |-> io_capability_reg[11:8] == 4'h0;
    endproperty
    a_rsv: assert property (p_rsv) else $error("reserved capability bits set");

    property p_ce;
        @(posedge clk_i) disable iff (!rst_n)
        ce_evt && !ms_rise |=> st_reg == S_TX && frame_reg[FLAG_BIT];
    endproperty
    a_ce: assert property (p_ce) else $error("error flag missing after bad checksum");

    property p_out_ck;
        @(posedge clk_i) disable iff (!rst_n)
        st_reg == S_TX && $changed(frame_reg) |->
            frame_reg[CK_MSB:CK_LSB] == bip4({4'h0, frame_reg[27:0]});
    endproperty
    a_out_ck: assert property (p_out_ck) else $error("outbound checksum wrong");

    property p_resend;
        @(posedge clk_i) disable iff (!rst_n)
        frame_done && ck_ok && in_word[FLAG_BIT] && !ms_rise |=> st_reg == S_TX && frame_reg == last_reg;
    endproperty
    a_resend: assert property (p_resend) else $error("last response not resent");

    property p_srq_pend;
        @(posedge clk_i) disable iff (!rst_n)
        xe_event_i && xe_pending_i && trig_reg[TRIG_XE_PEND] |=> !service_request_n_o;
    endproperty
    a_srq_pend: assert property (p_srq_pend) else $error("request not raised for pending error");

    property p_srq_quiet;
        @(posedge clk_i) disable iff (!rst_n)
        service_request_n_o && !srq_set |=> service_request_n_o;
    endproperty
    a_srq_quiet: assert property (p_srq_quiet) else $error("request raised without cause");

    property p_tx_idle;
        @(posedge clk_i) disable iff (!rst_n)
        st_reg == S_RX && !tx_busy |-> txd_o;
    endproperty
    a_tx_idle: assert property (p_tx_idle) else $error("tx line not idle high");

endmodule : sft_top
`default_nettype wire

//--- testbench/sft_host.sv
// serial frame transport: host controller model on the 8n1 link
// assumes the bench sets div to the bit period in clocks
`timescale 1ns/1ps
`default_nettype none
module sft_host (
    // link
    input  wire logic clk_i,
    input  wire logic txd_i,
    output logic      rxd_o
);
    int div = 2083;
    bit tmo = 0;
    initial rxd_o = 1'b1;
    // =========================================================
    // frames, msb byte first, lsb bit first
    task automatic send(input logic [31:0] w);
        for (int i = 0; i < 40; i++) begin
            @(posedge clk_i);
            rxd_o <= (i % 10 == 0) ? 1'b0 : (i % 10 == 9) ? 1'b1 : w[23 - 8 * (i / 10) + i % 10];
            repeat (div - 1) @(posedge clk_i);
        end
    endtask : send
    task automatic recv(output logic [31:0] w);
        w = '0;
        for (int k = 0; k < 4; k++) begin
            for (int n = 0; txd_i === 1'b1; n++) begin
                tmo = tmo | (n > 50000);
                if (tmo) return;
                @(posedge clk_i);
            end
            repeat (div / 2) @(posedge clk_i);
            for (int j = 0; j < 9; j++) begin
                repeat (div) @(posedge clk_i);
                if (j < 8) w[24 - 8 * k + j] = txd_i;
            end
        end
    endtask : recv
endmodule : sft_host
`default_nettype wire

//--- testbench/tb_serial_frame_transport.sv
// serial frame transport: self-checking bench with host model and app responder
// assumes link moved to rate code 4 so frames stay short
`timescale 1ns/1ps
`default_nettype none
module tb_serial_frame_transport;
    logic clk_i = 0, rstn_i = 0, rxd, msel_n = 0, txd, srq_n, cval, rval = 0;
    logic xe = 0, xp = 0, ack = 0, iwe = 0, twe = 0;
    logic [26:0] cmd, got;
    logic [25:0] rsp = '0;
    logic [15:0] wd = '0, ird, trd;
    int error_cnt = 0, num_checks = 0;
    sft_top DUT (.clk_i(clk_i), .rstn_i(rstn_i), .rxd_i(rxd), .module_select_n_i(msel_n), .txd_o(txd),
        .service_request_n_o(srq_n), .cmd_valid_o(cval), .cmd_packet_o(cmd), .rsp_valid_i(rval),
        .rsp_packet_i(rsp), .xe_event_i(xe), .xe_pending_i(xp), .srq_ack_i(ack), .io_capability_we_i(iwe),
        .io_capability_wdata_i(wd), .io_capability_rdata_o(ird), .srq_trig_we_i(twe), .srq_trig_wdata_i(wd),
        .srq_trig_rdata_o(trd));
    sft_host host (.clk_i(clk_i), .txd_i(txd), .rxd_o(rxd));
    initial forever #25 clk_i = ~clk_i;
    // =========================================================
    // application side answers each command one cycle later
    always @(posedge clk_i) begin
        rval <= cval;
        if (cval) got <= cmd;
    end
    task automatic chk(input string s, input logic [31:0] seen, input logic [31:0] exp);
        num_checks++;
        if (seen !== exp) begin
            error_cnt++;
            $display("wrong value %s exp %h seen %h", s, exp, seen);
        end
    endtask : chk
    task automatic stop_test();
        if (error_cnt == 0 && num_checks > 0) $display("*** PASS ***");
        else $display("*** FAIL ***");
        $finish;
    endtask : stop_test
    function automatic logic [3:0] ck(input logic [31:0] w);
        logic [7:0] b;
        b = w[31:24] ^ w[23:16] ^ w[15:8] ^ w[7:0];
        return b[7:4] ^ b[3:0];
    endfunction : ck
    function automatic logic [31:0] fin(input logic f, input logic [26:0] c);
        return {ck({4'h0, f, c}), f, c};
    endfunction : fin
    function automatic logic [31:0] fout(input logic e, input logic [25:0] p);
        return {ck({4'h0, e, 1'b1, p}), e, 1'b1, p};
    endfunction : fout
    task automatic wr(input bit t, input logic [15:0] d, input logic [15:0] e);
        @(posedge clk_i);
        iwe <= !t;
        twe <= t;
        wd <= d;
        @(posedge clk_i);
        iwe <= 1'b0;
        twe <= 1'b0;
        @(posedge clk_i);
        #1 chk("reg", t ? trd : ird, e);
    endtask : wr
    task automatic xchg(input logic [31:0] fi, input logic [31:0] exp);
        logic [31:0] w;
        fork
            host.send(fi);
            host.recv(w);
        join
        // let the last stop bit finish before the host may start again
        repeat (host.div) @(posedge clk_i);
        if (host.tmo) begin
            error_cnt++;
            stop_test();
        end
        chk("frame", w, exp);
    endtask : xchg
    initial begin
        logic [26:0] c;
        logic [31:0] last;
        logic [25:0] r;
        void'($urandom(85789));
        repeat (8) @(posedge clk_i);
        rstn_i <= 1'b1;
        repeat (4) @(posedge clk_i);
        #1 chk("io_capability", ird, 16'h0004);
        chk("trig", trd, 16'h0001);
        wr(0, 16'hffff, 16'h1004);
        wr(0, 16'h0f4f, 16'h0044);
        host.div = 173;
        c = 27'($urandom);
        r = 26'($urandom);
        @(posedge clk_i);
        rsp <= r;
        last = fout(0, r);
        xchg(fin(0, c), last);
        chk("cmd", got, c);
        @(posedge clk_i);
        rsp <= 26'($urandom);
        xchg(fin(1, 27'($urandom)), last);
        xchg(fin(0, c) ^ 32'h10000000, fout(1, last[25:0]));
        // xe from pending / non-pending under both trigger settings
        for (int i = 0; i < 4; i++) begin
            wr(1, i < 2 ? 16'h0001 : 16'h0002, i < 2 ? 16'h0001 : 16'h0002);
            xe <= 1'b1;
            xp <= i[0];
            @(posedge clk_i);
            xe <= 1'b0;
            @(posedge clk_i);
            #1 chk("srq", srq_n, (i == 1 || i == 2) ? 1'b0 : 1'b1);
            ack <= 1'b1;
            @(posedge clk_i);
            ack <= 1'b0;
        end
        for (int i = 0; i < 2; i++) begin
            wr(0, i ? 16'h0044 : 16'h1044, i ? 16'h0044 : 16'h1044);
            msel_n <= 1'b1;
            repeat (6) @(posedge clk_i);
            #1 chk("io_capability", ird, i ? 16'h0004 : 16'h1044);
            chk("txd", txd, 1'b1);
            msel_n <= 1'b0;
        end
        stop_test();
    end
endmodule : tb_serial_frame_transport
`default_nettype wire
